// ===== design/btx_pkg.sv
// Purpose: constants and types of the bit test, scan and bounds unit
// Assumes: one core clock; all clock counts are whole core clocks
// Notes:   opcode values other than OPC_ESCAPE and OPC_BOUND are the second byte after the 0F escape
package btx_pkg;
    // instruction kinds handled by the unit
    typedef enum logic [3:0] {
        BTX_NONE  = 4'b0000,
        BTX_BOUND = 4'b0001,
        BTX_BSF   = 4'b0010,
        BTX_BSR   = 4'b0011,
        BTX_BYTE_ORDER_REVERSE_OP = 4'b0100,
        BTX_BT    = 4'b0101,
        BTX_BTC   = 4'b0110,
        BTX_BTR   = 4'b0111,
        BTX_BTS   = 4'b1000
    } btx_op_type;

    // opcode bytes
    localparam logic [7:0] OPC_ESCAPE  = 8'h0F;
    localparam logic [7:0] OPC_BOUND   = 8'h62;
    localparam logic [7:0] OPC_SCAN_F  = 8'hBC;
    localparam logic [7:0] OPC_SCAN_R  = 8'hBD;
    localparam logic [4:0] OPC_SWAP_HI = 5'h19;  // C8..CF, low 3 bits reg
    localparam logic [7:0] OPC_BIT_IMM = 8'hBA;
    localparam logic [7:0] OPC_BT_REG  = 8'hA3;
    localparam logic [7:0] OPC_BTC_REG = 8'hBB;
    localparam logic [7:0] OPC_BTR_REG = 8'hB3;
    localparam logic [7:0] OPC_BTS_REG = 8'hAB;
    localparam logic [2:0] REGF_BT     = 3'h4;
    localparam logic [2:0] REGF_BTS    = 3'h5;
    localparam logic [2:0] REGF_BTR    = 3'h6;
    localparam logic [2:0] REGF_BTC    = 3'h7;

    // addressing form fields
    localparam logic [1:0] MOD_REG     = 2'h3;
    localparam logic [1:0] MOD_DISP8   = 2'h1;
    localparam logic [1:0] MOD_DISPW   = 2'h2;
    localparam logic [1:0] MOD_NODISP  = 2'h0;
    localparam logic [2:0] RM_DIRECT32 = 3'h5;
    localparam logic [2:0] RM_DIRECT16 = 3'h6;
    localparam logic [2:0] DISP_NONE   = 3'h0;
    localparam logic [2:0] DISP_BYTE   = 3'h1;
    localparam logic [2:0] DISP_WORD   = 3'h2;
    localparam logic [2:0] DISP_FULL   = 3'h4;

    // clock counts
    localparam logic [6:0] CLK_BOUND    = 7'h0B;
    localparam logic [6:0] CLK_SCAN_REG = 7'h05;
    localparam logic [6:0] CLK_SCAN_MEM = 7'h07;
    localparam logic [6:0] CLK_SCAN_MIS = 7'h09;
    localparam logic [6:0] CLK_SWAP     = 7'h04;
    localparam logic [6:0] CLK_BT_I_R   = 7'h03;
    localparam logic [6:0] CLK_BT_I_M   = 7'h04;
    localparam logic [6:0] CLK_BT_I_X   = 7'h05;
    localparam logic [6:0] CLK_BT_R_R   = 7'h03;
    localparam logic [6:0] CLK_BT_R_M   = 7'h06;
    localparam logic [6:0] CLK_BT_R_X   = 7'h07;
    localparam logic [6:0] CLK_BCR_I_R  = 7'h04;
    localparam logic [6:0] CLK_BCR_I_M  = 7'h05;
    localparam logic [6:0] CLK_BCR_I_X  = 7'h06;
    localparam logic [6:0] CLK_BCR_R_R  = 7'h05;
    localparam logic [6:0] CLK_BCR_R_M  = 7'h08;
    localparam logic [6:0] CLK_BCR_R_X  = 7'h09;
    localparam logic [6:0] CLK_BTS_I_R  = 7'h03;
    localparam logic [6:0] CLK_BTS_I_M  = 7'h05;
    localparam logic [6:0] CLK_BTS_I_X  = 7'h06;
    localparam logic [6:0] CLK_BTS_R_R  = 7'h04;
    localparam logic [6:0] CLK_BTS_R_M  = 7'h07;
    localparam logic [6:0] CLK_BTS_R_X  = 7'h08;
    localparam logic [6:0] CLK_EA_TWO   = 7'h01;
    localparam logic [6:0] CLK_MIS_RW   = 7'h02;
    localparam logic [6:0] CLK_MIS_RMW  = 7'h04;
    localparam logic [6:0] SCAN_EMPTY_N = 7'h20;
    localparam logic [6:0] CNT_LAST     = 7'h01;

    localparam logic [7:0]  BOUND_VECTOR = 8'h05;
    localparam logic [31:0] ONE_BIT      = 32'h0000_0001;
endpackage

// ===== design/btx_exec.sv
// Purpose: decode and timed execution of bounds check, bit scans,
//          byte swap and the four bit test forms
// Assumes: operands are presented with instr_valid; inputs synchronous
// Notes:   one instruction in flight; done marks the last clock
// Summary of operation
// - immediate marker and disp8/16/32 fields decoded
// - bounds check 11 clocks, out of range traps
// - forward scan 5/7+n, miss 9+n
// - reverse scan same timing, only zero flag
// - bit test decode and clock counts
// - complement form decode and clock counts
// - clear form decode and clock counts
// - set form decode and clock counts
// - two register address adds one clock
// - misaligned adds two, read-modify-write four
// - first count register, second memory operand
`timescale 1ns/100ps
module btx_exec (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        instr_valid,
    input  wire logic [7:0]  opcode0,
    input  wire logic [7:0]  opcode1,
    input  wire logic [7:0]  modrm,
    input  wire logic [7:0]  imm_byte,
    input  wire logic        addr32,
    input  wire logic [31:0] src_data,
    input  wire logic [31:0] dest_data,
    input  wire logic [31:0] bound_lo,
    input  wire logic [31:0] bound_hi,
    input  wire logic        cache_miss,
    input  wire logic        two_reg_ea,
    input  wire logic        misaligned,
    output logic             instr_taken,
    output logic             busy,
    output logic             done,
    output logic [31:0]      result,
    output logic             result_we,
    output logic             carry_flag,
    output logic             carry_we,
    output logic             zero_flag,
    output logic             zero_we,
    output logic             exc_req,
    output logic [7:0]       exc_vector,
    output logic [2:0]       disp_bytes
);
    typedef struct packed {
        logic                busy;
        logic [6:0]          cnt;
        btx_pkg::btx_op_type op;
        logic [31:0]         result;
        logic                carry;
        logic                zero;
        logic                trap;
        logic                done;
        logic [2:0]          disp;
    } btx_state_type;

    btx_state_type       st;
    btx_state_type       next_st;
    btx_pkg::btx_op_type dec_op;
    logic                is_mem;
    logic                imm_form;

    // opcode decode; only members of this group are taken
    always_comb begin
        dec_op   = btx_pkg::BTX_NONE;
        imm_form = 1'b0;
        if (opcode0 == btx_pkg::OPC_BOUND) begin
            dec_op = btx_pkg::BTX_BOUND;
        end else if (opcode0 == btx_pkg::OPC_ESCAPE) begin
            if (opcode1 == btx_pkg::OPC_SCAN_F) begin
                dec_op = btx_pkg::BTX_BSF;
            end else if (opcode1 == btx_pkg::OPC_SCAN_R) begin
                dec_op = btx_pkg::BTX_BSR;
            end else if (opcode1[7:3] == btx_pkg::OPC_SWAP_HI) begin
                dec_op = btx_pkg::BTX_BYTE_ORDER_REVERSE_OP;
            end else if (opcode1 == btx_pkg::OPC_BIT_IMM) begin
                imm_form = 1'b1;
                unique case (modrm[5:3])
                    btx_pkg::REGF_BT:  dec_op = btx_pkg::BTX_BT;
                    btx_pkg::REGF_BTC: dec_op = btx_pkg::BTX_BTC;
                    btx_pkg::REGF_BTR: dec_op = btx_pkg::BTX_BTR;
                    btx_pkg::REGF_BTS: dec_op = btx_pkg::BTX_BTS;
                    default:           dec_op = btx_pkg::BTX_NONE;
                endcase
            end else if (opcode1 == btx_pkg::OPC_BT_REG) begin
                dec_op = btx_pkg::BTX_BT;
            end else if (opcode1 == btx_pkg::OPC_BTC_REG) begin
                dec_op = btx_pkg::BTX_BTC;
            end else if (opcode1 == btx_pkg::OPC_BTR_REG) begin
                dec_op = btx_pkg::BTX_BTR;
            end else if (opcode1 == btx_pkg::OPC_BTS_REG) begin
                dec_op = btx_pkg::BTX_BTS;
            end
        end
    end

    // byte swap names its register in the opcode, never memory
    assign is_mem = (dec_op != btx_pkg::BTX_BYTE_ORDER_REVERSE_OP)
                    && (modrm[7:6] != btx_pkg::MOD_REG);
    assign instr_taken = instr_valid && !st.busy
                         && (dec_op != btx_pkg::BTX_NONE);

    // picks register, memory hit or miss count
    function automatic logic [6:0] pick(input logic mem, input logic miss,
                                        input logic [6:0] r,
                                        input logic [6:0] m,
                                        input logic [6:0] x);
        if (!mem) begin
            pick = r;
        end else if (miss) begin
            pick = x;
        end else begin
            pick = m;
        end
    endfunction

    // next state: take, count down, finish
    always_comb begin
        logic [6:0]  base;
        logic [6:0]  scan_n;
        logic [4:0]  idx;
        logic [31:0] mask;
        logic        rmw;
        logic        miss;
        base    = '0;
        scan_n  = btx_pkg::SCAN_EMPTY_N;
        idx     = imm_form ? imm_byte[4:0] : src_data[4:0];
        mask    = btx_pkg::ONE_BIT << idx;
        rmw     = 1'b0;
        miss    = cache_miss;
        next_st = st;
        next_st.done = 1'b0;
        if (dec_op == btx_pkg::BTX_BSF) begin
            for (int i = 31; i >= 0; i--) begin
                if (src_data[i]) begin
                    scan_n = 7'(i);
                end
            end
        end else begin
            for (int i = 0; i < 32; i++) begin
                if (src_data[i]) begin
                    scan_n = 7'(31 - i);
                end
            end
        end
        if (instr_taken) begin
            next_st.op   = dec_op;
            next_st.busy = 1'b1;
            next_st.trap = 1'b0;
            unique case (dec_op)
                btx_pkg::BTX_BOUND: begin
                    base = btx_pkg::CLK_BOUND;
                    next_st.trap = ($signed(src_data) < $signed(bound_lo))
                        || ($signed(src_data) > $signed(bound_hi));
                end
                btx_pkg::BTX_BSF, btx_pkg::BTX_BSR: begin
                    base = pick(is_mem, miss, btx_pkg::CLK_SCAN_REG,
                                btx_pkg::CLK_SCAN_MEM,
                                btx_pkg::CLK_SCAN_MIS) + scan_n;
                    next_st.zero = (src_data == '0);
                    next_st.result = (src_data == '0) ? dest_data
                                     : {25'h0, scan_n};
                    if (dec_op == btx_pkg::BTX_BSR) begin
                        next_st.result = (src_data == '0) ? dest_data
                            : {25'h0, 7'(31) - scan_n};
                    end
                end
                btx_pkg::BTX_BYTE_ORDER_REVERSE_OP: begin
                    base = btx_pkg::CLK_SWAP;
                    next_st.result = {dest_data[7:0], dest_data[15:8],
                                      dest_data[23:16], dest_data[31:24]};
                end
                btx_pkg::BTX_BT: begin
                    base = imm_form
                        ? pick(is_mem, miss, btx_pkg::CLK_BT_I_R,
                               btx_pkg::CLK_BT_I_M, btx_pkg::CLK_BT_I_X)
                        : pick(is_mem, miss, btx_pkg::CLK_BT_R_R,
                               btx_pkg::CLK_BT_R_M,
                               btx_pkg::CLK_BT_R_X);
                end
                btx_pkg::BTX_BTC, btx_pkg::BTX_BTR: begin
                    rmw  = 1'b1;
                    base = imm_form
                        ? pick(is_mem, miss, btx_pkg::CLK_BCR_I_R,
                               btx_pkg::CLK_BCR_I_M, btx_pkg::CLK_BCR_I_X)
                        : pick(is_mem, miss, btx_pkg::CLK_BCR_R_R,
                               btx_pkg::CLK_BCR_R_M,
                               btx_pkg::CLK_BCR_R_X);
                    next_st.result = (dec_op == btx_pkg::BTX_BTC)
                        ? (dest_data ^ mask)
                        : (dest_data & ~mask);
                end
                btx_pkg::BTX_BTS: begin
                    rmw  = 1'b1;
                    base = imm_form
                        ? pick(is_mem, miss, btx_pkg::CLK_BTS_I_R,
                               btx_pkg::CLK_BTS_I_M, btx_pkg::CLK_BTS_I_X)
                        : pick(is_mem, miss, btx_pkg::CLK_BTS_R_R,
                               btx_pkg::CLK_BTS_R_M,
                               btx_pkg::CLK_BTS_R_X);
                    next_st.result = dest_data | mask;
                end
                default: base = btx_pkg::CLK_SWAP;
            endcase
            next_st.carry = |(dest_data & mask);
            if (is_mem && two_reg_ea) begin
                base = base + btx_pkg::CLK_EA_TWO;
            end
            if (is_mem && misaligned) begin
                base = base + (rmw ? btx_pkg::CLK_MIS_RMW
                                   : btx_pkg::CLK_MIS_RW);
            end
            next_st.cnt = base - btx_pkg::CNT_LAST;
            // displacement size from the addressing form
            if (modrm[7:6] == btx_pkg::MOD_DISP8) begin
                next_st.disp = btx_pkg::DISP_BYTE;
            end else if (modrm[7:6] == btx_pkg::MOD_DISPW) begin
                next_st.disp = addr32 ? btx_pkg::DISP_FULL
                                      : btx_pkg::DISP_WORD;
            end else if (modrm[7:6] == btx_pkg::MOD_NODISP
                         && addr32 && modrm[2:0] == btx_pkg::RM_DIRECT32) begin
                next_st.disp = btx_pkg::DISP_FULL;
            end else if (modrm[7:6] == btx_pkg::MOD_NODISP
                         && !addr32 && modrm[2:0] == btx_pkg::RM_DIRECT16) begin
                next_st.disp = btx_pkg::DISP_WORD;
            end else begin
                next_st.disp = btx_pkg::DISP_NONE;
            end
        end else if (st.busy) begin
            next_st.cnt = st.cnt - btx_pkg::CNT_LAST;
            if (st.cnt == btx_pkg::CNT_LAST) begin
                next_st.busy = 1'b0;
                next_st.done = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // completion strobes; writes happen only in the done cycle
    assign busy       = st.busy;
    assign done       = st.done;
    assign result     = st.result;
    assign carry_flag = st.carry;
    assign zero_flag  = st.zero;
    assign disp_bytes = st.disp;
    assign exc_vector = btx_pkg::BOUND_VECTOR;
    assign exc_req    = st.done && st.op == btx_pkg::BTX_BOUND && st.trap;
    assign zero_we    = st.done && (st.op == btx_pkg::BTX_BSF
                                    || st.op == btx_pkg::BTX_BSR);
    assign carry_we   = st.done && (st.op == btx_pkg::BTX_BT
        || st.op == btx_pkg::BTX_BTC || st.op == btx_pkg::BTX_BTR
        || st.op == btx_pkg::BTX_BTS);
    assign result_we  = st.done && st.op != btx_pkg::BTX_BT
        && st.op != btx_pkg::BTX_BOUND && !(zero_we && st.zero);

    // checks
    logic plain;
    assign plain = instr_taken && !two_reg_ea && !misaligned;

    bound_time_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        plain && dec_op == btx_pkg::BTX_BOUND
        |-> ##1 !done [*8] ##3 done)
        else $error("bounds check not done in 11 clocks");
    bound_trap_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        plain && dec_op == btx_pkg::BTX_BOUND
        && $signed(src_data) < $signed(bound_lo)
        |-> ##11 exc_req && exc_vector == 8'h05)
        else $error("bounds trap missing");
    scan_fwd_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        plain && dec_op == btx_pkg::BTX_BSF && !is_mem && src_data[0]
        |-> ##5 done && zero_we)
        else $error("forward scan timing wrong");
    scan_rev_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        plain && dec_op == btx_pkg::BTX_BSR && is_mem && cache_miss
        && src_data[31] |-> ##9 done && !carry_we && result == 32'h1F)
        else $error("reverse scan timing or flags wrong");
    bt_imm_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        plain && dec_op == btx_pkg::BTX_BT && imm_form && !is_mem
        |-> ##3 done && carry_we && !result_we)
        else $error("bit test timing wrong");
    btc_miss_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        plain && dec_op == btx_pkg::BTX_BTC && !imm_form && is_mem
        && cache_miss |-> ##9 done)
        else $error("complement miss timing wrong");
    btr_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        plain && dec_op == btx_pkg::BTX_BTR && !is_mem && imm_form
        && dest_data[imm_byte[4:0]]
        |-> ##4 done && carry_flag && !result[$past(imm_byte[4:0], 4)])
        else $error("clear form carry or result wrong");
    bts_hit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        plain && dec_op == btx_pkg::BTX_BTS && !imm_form && is_mem
        && !cache_miss |-> ##7 done)
        else $error("set form hit timing wrong");
    ea_two_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        instr_taken && two_reg_ea && !misaligned && is_mem && !cache_miss
        && dec_op == btx_pkg::BTX_BT && imm_form |-> ##5 done)
        else $error("two register address extra clock missing");
    misalign_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        instr_taken && misaligned && !two_reg_ea && is_mem && !cache_miss
        && dec_op == btx_pkg::BTX_BTS && imm_form |-> ##9 done)
        else $error("misaligned extra clocks wrong");
    swap_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        instr_taken && dec_op == btx_pkg::BTX_BYTE_ORDER_REVERSE_OP
        |-> ##4 done && !carry_we && !zero_we && result_we)
        else $error("byte swap timing or flags wrong");
    imm_decode_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        instr_valid && opcode0 == btx_pkg::OPC_ESCAPE
        && opcode1 == btx_pkg::OPC_BIT_IMM && !modrm[5] |-> !instr_taken)
        else $error("undefined immediate form taken");

    trap_c: cover property (@(posedge sys_clk) disable iff (!rstn) exc_req);
    scan_c: cover property (@(posedge sys_clk) disable iff (!rstn)
        done && zero_we && !zero_flag);
    rmw_c: cover property (@(posedge sys_clk) disable iff (!rstn)
        done && carry_we && result_we);
    b2b_c: cover property (@(posedge sys_clk) disable iff (!rstn)
        done && instr_taken);
endmodule

// ===== tb/btx_exec_bench.sv
// Purpose: self-checking random bench for the bit test, scan, bound unit
// Assumes: inputs change at the falling edge, outputs read there too
// Notes:   instructions run back to back; expectations from bench tables
`timescale 1ns/100ps
module bit_test_scan_bounds_exec_bench;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        instr_valid = 1'b0;
    logic [7:0]  opcode0 = 8'h00, opcode1 = 8'h00, modrm = 8'h00;
    logic [7:0]  imm_byte = 8'h00;
    logic        addr32 = 1'b0, cache_miss = 1'b0;
    logic        two_reg_ea = 1'b0, misaligned = 1'b0;
    logic [31:0] src_data = 32'h0, dest_data = 32'h0;
    logic [31:0] bound_lo = 32'h0, bound_hi = 32'h0;
    logic        instr_taken, busy, done, result_we, carry_flag, carry_we;
    logic        zero_flag, zero_we, exc_req;
    logic [31:0] result;
    logic [7:0]  exc_vector;
    logic [2:0]  disp_bytes;
    int          fail_count = 0;
    int          total_checks = 0;
    // register / hit / miss clocks per kind, before extras
    int          clk_tab [12][3] = '{'{11, 11, 11}, '{5, 7, 9}, '{5, 7, 9},
        '{4, 4, 4}, '{3, 4, 5}, '{3, 6, 7}, '{4, 5, 6}, '{5, 8, 9},
        '{4, 5, 6}, '{5, 8, 9}, '{3, 5, 6}, '{4, 7, 8}};
    logic [7:0]  op1_tab [12] = '{8'h00, 8'hBC, 8'hBD, 8'hC8, 8'hBA, 8'hA3,
        8'hBA, 8'hBB, 8'hBA, 8'hB3, 8'hBA, 8'hAB};
    logic [2:0]  regf_tab [12] = '{3'h2, 3'h2, 3'h2, 3'h2, 3'h4, 3'h2,
        3'h7, 3'h2, 3'h6, 3'h2, 3'h5, 3'h2};

    // core clock, 8 ns period
    always #4 sys_clk = ~sys_clk;

    btx_exec i_btx_exec (.sys_clk(sys_clk), .rstn(rstn),
        .instr_valid(instr_valid), .opcode0(opcode0), .opcode1(opcode1),
        .modrm(modrm), .imm_byte(imm_byte), .addr32(addr32),
        .src_data(src_data), .dest_data(dest_data), .bound_lo(bound_lo),
        .bound_hi(bound_hi), .cache_miss(cache_miss),
        .two_reg_ea(two_reg_ea), .misaligned(misaligned),
        .instr_taken(instr_taken), .busy(busy), .done(done),
        .result(result), .result_we(result_we), .carry_flag(carry_flag),
        .carry_we(carry_we), .zero_flag(zero_flag), .zero_we(zero_we),
        .exc_req(exc_req), .exc_vector(exc_vector),
        .disp_bytes(disp_bytes));

    // scan distance: zero source gives 32
    function automatic int scan_n(bit rev, logic [31:0] v);
        scan_n = 32;
        for (int i = 0; i < 32; i++)
            if (v[rev ? 31 - i : i] && scan_n == 32) scan_n = i;
    endfunction

    // clock count including address and alignment extras
    function automatic int exp_clk(int k, bit mem, logic ms, logic tw,
                                   logic mi, int n);
        exp_clk = clk_tab[k][mem ? (ms ? 2 : 1) : 0];
        if (k == 1 || k == 2) exp_clk += n;
        if (mem && tw) exp_clk += 1;
        if (mem && mi) exp_clk += (k >= 6) ? 4 : 2;
    endfunction

    // displacement length from addressing form
    function automatic logic [2:0] exp_disp(logic [1:0] md, logic [2:0] rm,
                                            logic a3);
        case (md)
            2'h0: exp_disp = (a3 && rm == 3'h5) ? 3'h4 :
                             (!a3 && rm == 3'h6) ? 3'h2 : 3'h0;
            2'h1: exp_disp = 3'h1;
            2'h2: exp_disp = a3 ? 3'h4 : 3'h2;
            default: exp_disp = 3'h0;
        endcase
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // wide enough for flag and strobe bits packed above a data word
    task automatic chk(logic [39:0] got, logic [39:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // present one instruction, time it, check its outcome
    task automatic run_op(int k, logic [1:0] md, logic [2:0] rm,
        logic [7:0] im, logic [31:0] s, logic [31:0] d, logic ms,
        logic tw, logic mi, logic a3);
        bit          mem;
        int          n, t, cnt;
        logic [4:0]  ix;
        logic [31:0] er, m1;
        logic        oob;
        mem = (md != 2'h3) && (k != 3);
        n = scan_n(k == 2, s);
        t = exp_clk(k, mem, ms, tw, mi, n);
        ix = (op1_tab[k] == 8'hBA) ? im[4:0] : s[4:0];
        m1 = 32'h1 << ix;
        oob = ($signed(s) < $signed(bound_lo)) ||
              ($signed(s) > $signed(bound_hi));
        instr_valid = 1'b1;
        opcode0 = (k == 0) ? 8'h62 : 8'h0F;
        opcode1 = (k == 3) ? (8'hC8 | {5'h00, rm}) : op1_tab[k];
        modrm = {md, regf_tab[k], rm};
        imm_byte = im;
        src_data = s;
        dest_data = d;
        cache_miss = ms;
        two_reg_ea = tw;
        misaligned = mi;
        addr32 = a3;
        #1;
        chk(instr_taken, 1'b1);
        @(posedge sys_clk);
        cnt = 0;
        do begin
            @(negedge sys_clk);
            cnt++;
            if (cnt > 100) begin
                fail_count++;
                print_verdict();
            end
            if (done !== 1'b1) begin
                #1;
                chk(instr_taken, 1'b0);
            end
        end while (done !== 1'b1);
        chk(cnt, t);
        chk(exc_req, k == 0 && oob);
        if (k != 3) chk(disp_bytes, exp_disp(md, rm, a3));
        if (k == 0) chk(exc_vector, 8'h05);
        if (k >= 4) chk({carry_we, carry_flag}, {1'b1, d[ix]});
        if (k >= 6) begin
            er = (k < 8) ? d ^ m1 : (k < 10) ? d & ~m1 : d | m1;
            chk({result_we, result}, {1'b1, er});
        end
        if (k == 1 || k == 2) begin
            chk({zero_we, zero_flag, carry_we}, {2'b10 | (s == 0), 1'b0});
            if (s != 0) chk(result, (k == 1) ? n : 31 - n);
        end
        if (k == 3) begin
            er = {d[7:0], d[15:8], d[23:16], d[31:24]};
            chk({result_we, carry_we, zero_we, result}, {3'b100, er});
        end
    endtask

    // a request that must not be taken
    task automatic refuse(logic [7:0] o0, logic [7:0] o1, logic [2:0] rf);
        instr_valid = 1'b1;
        opcode0 = o0;
        opcode1 = o1;
        modrm = {2'h3, rf, 3'h0};
        repeat (3) begin
            #1;
            chk({instr_taken, busy, done}, 3'h0);
            @(negedge sys_clk);
        end
    endtask

    // reset, corner cases, random traffic, refusals
    initial begin
        int k;
        logic [1:0] md;
        void'($urandom(32'h96dbc0c0));
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({busy, done, disp_bytes, result}, 35'h0);
        rstn = 1'b1;
        bound_lo = 32'hFFFF_FFF0;
        bound_hi = 32'h0000_0010;
        run_op(0, 2'h1, 3'h0, 8'h00, 32'h0000_0010, 32'h0, 0, 1, 1, 1);
        run_op(0, 2'h2, 3'h3, 8'h00, 32'h0000_0011, 32'h0, 1, 0, 0, 0);
        run_op(0, 2'h0, 3'h5, 8'h00, 32'hFFFF_FFEF, 32'h0, 0, 0, 0, 1);
        run_op(1, 2'h3, 3'h1, 8'h00, 32'h0, 32'h5, 0, 0, 0, 1);
        run_op(2, 2'h0, 3'h5, 8'h00, 32'h1, 32'h0, 1, 1, 1, 1);
        run_op(1, 2'h1, 3'h0, 8'h00, 32'h8000_0000, 32'h0, 0, 1, 0, 0);
        for (int j = 3; j < 12; j++)
            run_op(j, 2'h0, 3'h6, 8'h3F, 32'hFFFF_FFFF, 32'h8000_0000,
                   0, 1, 1, 0);
        $display("corner tests done");
        for (int i = 0; i < 300; i++) begin
            k = $urandom_range(11, 0);
            md = $urandom_range(3, 0);
            if (k == 0 && md == 2'h3) md = 2'h0;
            bound_lo = 0 - $urandom_range(64, 0);
            bound_hi = $urandom_range(64, 0);
            run_op(k, md, $urandom_range(7, 0), $urandom,
                   (k == 0) ? $urandom_range(160, 0) - 80
                            : $urandom >> $urandom_range(32, 0),
                   $urandom, $urandom_range(1, 0), $urandom_range(1, 0),
                   $urandom_range(1, 0), $urandom_range(1, 0));
        end
        $display("random tests done");
        // let the last done pulse pass before the refusals are checked
        instr_valid = 1'b0;
        @(negedge sys_clk);
        for (int r = 0; r < 4; r++)
            refuse(8'h0F, 8'hBA, r);
        refuse(8'h90, 8'h00, 3'h0);
        refuse(8'h0F, 8'h00, 3'h0);
        instr_valid = 1'b0;
        $display("refusal tests done");
        print_verdict();
    end
endmodule
